// ### option_word_config_decode.v
// option word decoder: latches two option words at reset release and drives static settings
//
// Function
// - reset-mode bit 0 starts green, 1 normal
// - power bit 0 low power, 1 normal
// - two-bit field sets low-voltage trip level
// - low-voltage reset only after 5 us low
// - pin bit 0 reset input, 1 gpio
// - watchdog bit 0 enables, 1 disables
// - width bit: 32 clocks if 1, 8 if 0
// - low crystal mode forces 8-clock width
// - filter enable bit 0 off, 1 on
// - filter off in green, idle, sleep
// - slow clock bit 0 32kHz, 1 16kHz
// - programmer-supplied six-bit trim applied to rc
// - two-bit field picks rc frequency
// - three-bit field picks clock source
// - clock-out type: 0 open drain, 1 push-pull
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`include "option_word_consts.vh"
module option_word_config_decode (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // option words from non-volatile store
  input wire [14:0] option_word0,
  input wire [14:0] option_word1,
  // analog monitors and pins
  input wire supply_below_trip,
  input wire shared_reset_io_pin_in,
  // decoded core settings
  output reg config_valid,
  output reg start_green,
  output reg low_power,
  output reg [1:0] lowvolt_level,
  output reg lowvolt_reset,
  output reg reset_pin_is_reset,
  output reg ext_reset_n,
  output reg gpio_in,
  output reg watchdog_enable,
  output reg filter_active,
  output reg [5:0] filter_len,
  output reg slow_clock_32k,
  output reg [5:0] rc_trim,
  output reg [1:0] rc_freq,
  output reg [2:0] osc_mode,
  output reg osc_mode_valid,
  // clock output on the oscillator input pin
  output reg clkout_o,
  output reg clkout_oe_n
);

////////////////////////////////////////////////////////////////////////////////
// load sequencer

localparam ST_WAIT = 3'b001;
localparam ST_LOAD = 3'b010;
localparam ST_RUN = 3'b100;

reg [2:0] state_r;
reg [2:0] state_nxt;
reg [14:0] word0_r;
reg [14:0] word1_r;
reg load_done_r;

always @* begin
  state_nxt = state_r;
  case (state_r)
    ST_WAIT: state_nxt = ST_LOAD;
    ST_LOAD: state_nxt = ST_RUN;
    ST_RUN: state_nxt = ST_RUN;
    default: state_nxt = ST_WAIT;
  endcase
end

// words are caught by a clocked edge after release, never by the async reset
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    state_r <= ST_WAIT;
    word0_r <= `OPT0_DEFAULT;
    word1_r <= `OPT1_DEFAULT;
    load_done_r <= 1'b0;
  end else begin
    state_r <= state_nxt;
    if (state_r == ST_LOAD) begin
      word0_r <= option_word0;
      word1_r <= option_word1;
      load_done_r <= 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// field decode

// valid oscillator codes; 000 and 001 are not defined
function osc_ok;
  input [2:0] code;
  begin
    osc_ok = (code[2] == 1'b1) || (code == `OSC_RC_IO) || (code == `OSC_RC_CLKOUT);
  end
endfunction

wire [1:0] lvr_field = {word0_r[`W0_LVR_HI], word0_r[`W0_LVR_LO]};
wire [2:0] osc_field = word1_r[`W1_OSC_HI:`W1_OSC_LO];
wire [1:0] rcf_field = {word1_r[`W1_RCF_HI], word1_r[`W1_RCF_LO]};
wire [5:0] trim_field = word1_r[`W1_TRIM_HI:`W1_TRIM_LO];
// top bit of word 1 is trusted to be 1 and is not looked at
wire osc_low_xtal = (osc_field == `OSC_XTAL_LOW);
wire rc_clkout_mode = (osc_field == `OSC_RC_CLKOUT);

////////////////////////////////////////////////////////////////////////////////
// cpu mode register, software-steered; starts from the option after load

reg [1:0] cpu_mode_r;
reg [1:0] cpu_mode_nxt;

wire apb_setup = psel && !penable;
wire apb_write = psel && penable && pready && pwrite;
wire hit_mode = (paddr == `REG_MODE);

always @* begin
  cpu_mode_nxt = cpu_mode_r;
  if (state_r == ST_LOAD) begin
    if (!option_word0[`W0_RESET_MODE])
      cpu_mode_nxt = `CPU_GREEN;
    else
      cpu_mode_nxt = `CPU_NORMAL;
  end else if (apb_write && hit_mode && !pslverr) begin
    cpu_mode_nxt = pwdata[1:0];
  end
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn)
    cpu_mode_r <= `CPU_NORMAL;
  else
    cpu_mode_r <= cpu_mode_nxt;
end

////////////////////////////////////////////////////////////////////////////////
// noise filter on the shared pin

reg [5:0] filt_len_nxt;
reg filt_on_nxt;

always @* begin
  if (osc_low_xtal)
    filt_len_nxt = `FILT_SHORT_CYC;
  else if (word0_r[`W0_FILT_WIDTH])
    filt_len_nxt = `FILT_LONG_CYC;
  else
    filt_len_nxt = `FILT_SHORT_CYC;
  // low-power modes run without the filter
  filt_on_nxt = word0_r[`W0_FILT_EN] && (cpu_mode_r == `CPU_NORMAL);
end

wire pin_filtered;

pulse_filter #(
  .RST_VAL(1'b1)
) u_pin_filter (
  .pclk(pclk),
  .presetn(presetn),
  .bypass(!filter_active),
  .len(filter_len),
  .din(shared_reset_io_pin_in),
  .dout(pin_filtered)
);

////////////////////////////////////////////////////////////////////////////////
// low-voltage reset: supply must stay low for the full window

localparam integer LVR_LEN_I = `LVR_FILTER_CYC;
localparam [5:0] LVR_LEN = LVR_LEN_I[5:0];

wire supply_low_held;

pulse_filter #(
  .RST_VAL(1'b0)
) u_lvr_filter (
  .pclk(pclk),
  .presetn(presetn),
  .bypass(1'b0),
  .len(LVR_LEN),
  .din(supply_below_trip),
  .dout(supply_low_held)
);

////////////////////////////////////////////////////////////////////////////////
// instruction-cycle clock for the clock-out pin

reg icyc_r;

always @(posedge pclk or negedge presetn) begin
  if (!presetn)
    icyc_r <= 1'b0;
  else
    icyc_r <= ~icyc_r;
end

////////////////////////////////////////////////////////////////////////////////
// registered outputs; word-derived settings hold still once loaded, pin, brown-out, filter-on and clock-out outputs keep changing

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    config_valid <= 1'b0;
    start_green <= 1'b0;
    low_power <= 1'b0;
    lowvolt_level <= `LVR_POR_ONLY;
    lowvolt_reset <= 1'b0;
    reset_pin_is_reset <= 1'b0;
    ext_reset_n <= 1'b1;
    gpio_in <= 1'b1;
    watchdog_enable <= 1'b0;
    filter_active <= 1'b0;
    filter_len <= `FILT_SHORT_CYC;
    slow_clock_32k <= 1'b0;
    rc_trim <= 6'h3f;
    rc_freq <= `RCF_4M;
    osc_mode <= `OSC_RC_IO;
    osc_mode_valid <= 1'b1;
    clkout_o <= 1'b0;
    clkout_oe_n <= 1'b1;
  end else begin
    config_valid <= load_done_r;
    start_green <= !word0_r[`W0_RESET_MODE];
    low_power <= !word0_r[`W0_POWER];
    lowvolt_level <= lvr_field;
    // por-only setting never trips
    lowvolt_reset <= load_done_r && (lvr_field != `LVR_POR_ONLY) && supply_low_held;
    reset_pin_is_reset <= !word0_r[`W0_RESET_PIN];
    if (!word0_r[`W0_RESET_PIN]) begin
      ext_reset_n <= pin_filtered;
      gpio_in <= 1'b1;
    end else begin
      ext_reset_n <= 1'b1;
      gpio_in <= pin_filtered;
    end
    watchdog_enable <= load_done_r && !word0_r[`W0_WDT_DIS];
    filter_active <= load_done_r && filt_on_nxt;
    filter_len <= filt_len_nxt;
    slow_clock_32k <= !word1_r[`W1_SLOW_CLK];
    rc_trim <= trim_field;
    rc_freq <= rcf_field;
    osc_mode <= osc_field;
    osc_mode_valid <= osc_ok(osc_field);
    if (load_done_r && rc_clkout_mode) begin
      if (word1_r[`W1_CLKOUT_TYPE]) begin
        clkout_o <= icyc_r;
        clkout_oe_n <= 1'b0;
      end else begin
        // open drain: only pull low, release for high
        clkout_o <= 1'b0;
        clkout_oe_n <= icyc_r;
      end
    end else begin
      clkout_o <= 1'b0;
      clkout_oe_n <= 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// apb slave: one wait-free access phase, data prepared in setup

function addr_mapped;
  input [11:0] a;
  begin
    addr_mapped = (a == `REG_WORD0) || (a == `REG_WORD1) || (a == `REG_STATUS) || (a == `REG_MODE);
  end
endfunction

reg [31:0] rdata_nxt;

always @* begin
  rdata_nxt = 32'h00000000;
  case (paddr)
    `REG_WORD0: rdata_nxt = {17'h00000, word0_r};
    `REG_WORD1: rdata_nxt = {17'h00000, word1_r};
    `REG_STATUS: rdata_nxt = {24'h000000, osc_mode_valid, filter_active, pin_filtered,
                              supply_low_held, lowvolt_reset, 2'h0, config_valid};
    `REG_MODE: rdata_nxt = {30'h00000000, cpu_mode_r};
    default: rdata_nxt = 32'h00000000;
  endcase
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    pready <= 1'b0;
    pslverr <= 1'b0;
    prdata <= 32'h00000000;
  end else if (apb_setup) begin
    pready <= 1'b1;
    // writes to read-only words are refused like unmapped ones
    pslverr <= !addr_mapped(paddr) || (pwrite && !hit_mode);
    prdata <= pwrite ? 32'h00000000 : rdata_nxt;
  end else begin
    pready <= 1'b0;
    pslverr <= 1'b0;
  end
end

endmodule

// ### option_word_consts.vh
// constants for the option word decoder: bit fields, defaults, register map, timing
`ifndef OPTION_WORD_CONSTS_VH
`define OPTION_WORD_CONSTS_VH

// option word width and factory default images
`define OPT_W 15
`define OPT0_DEFAULT 15'h27ff
`define OPT1_DEFAULT 15'h7fe7

// word 0 fields
`define W0_RESET_MODE 10
`define W0_POWER 9
`define W0_LVR_HI 8
`define W0_LVR_LO 7
`define W0_RESET_PIN 6
`define W0_WDT_DIS 5
`define W0_FILT_WIDTH 4
`define W0_FILT_EN 3

// word 1 fields
`define W1_UNUSED_TOP 14
`define W1_SLOW_CLK 13
`define W1_TRIM_HI 12
`define W1_TRIM_LO 7
`define W1_RCF_HI 6
`define W1_RCF_LO 5
`define W1_OSC_HI 3
`define W1_OSC_LO 1
`define W1_CLKOUT_TYPE 0

// low-voltage reset level codes
`define LVR_4V0 2'h0
`define LVR_3V5 2'h1
`define LVR_2V7 2'h2
`define LVR_POR_ONLY 2'h3

// rc frequency codes
`define RCF_1M 2'h0
`define RCF_8M 2'h1
`define RCF_16M 2'h2
`define RCF_4M 2'h3

// oscillator mode codes
`define OSC_XTAL_FAST 3'h7
`define OSC_XTAL_HMID 3'h6
`define OSC_XTAL_MID 3'h5
`define OSC_XTAL_LOW 3'h4
`define OSC_RC_IO 3'h3
`define OSC_RC_CLKOUT 3'h2

// cpu power modes held in the mode register
`define CPU_NORMAL 2'h0
`define CPU_GREEN 2'h1
`define CPU_IDLE 2'h2
`define CPU_SLEEP 2'h3

// apb register byte offsets
`define REG_WORD0 12'h000
`define REG_WORD1 12'h004
`define REG_STATUS 12'h008
`define REG_MODE 12'h00c

// timing
`define PCLK_PERIOD_NS 100
`define LVR_FILTER_NS 5000
`define LVR_FILTER_CYC ((`LVR_FILTER_NS + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)
`define FILT_SHORT_CYC 6'h08
`define FILT_LONG_CYC 6'h20

`endif

// ### pulse_filter.v
// pulse filter: output follows input only after it has held a new level for len cycles
`timescale 1ns/100ps
module pulse_filter #(
  parameter RST_VAL = 1'b0
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire bypass,
  input wire [5:0] len,
  // data
  input wire din,
  output reg dout
);

reg [5:0] cnt_r;

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    cnt_r <= 6'h00;
    dout <= RST_VAL;
  end else if (bypass || din == dout) begin
    cnt_r <= 6'h00;
    dout <= din;
  end else if (cnt_r + 6'h01 >= len) begin
    // level held for len cycles in a row
    cnt_r <= 6'h00;
    dout <= din;
  end else begin
    cnt_r <= cnt_r + 6'h01;
  end
end

endmodule

// ### option_programmer.sv
// device programmer model holding the two stored option words
`timescale 1ns/100ps
module option_programmer (
  // images requested by the bench
  input wire logic [14:0] img0,
  input wire logic [14:0] img1,
  // words as burned
  output logic [14:0] word0,
  output logic [14:0] word1
);
  assign word0 = img0;
  // trim passes through untouched, unused top bit always written high
  assign word1 = {1'b1, img1[13:0]};
endmodule

// ### option_word_checks_assertions.sv
// concurrent checks on the option word decoder ports
`timescale 1ns/100ps
module option_word_checks (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // stored words and monitor
  input wire logic [14:0] option_word0,
  input wire logic [14:0] option_word1,
  input wire logic supply_below_trip,
  // decoded settings
  input wire logic config_valid,
  input wire logic start_green,
  input wire logic low_power,
  input wire logic [1:0] lowvolt_level,
  input wire logic lowvolt_reset,
  input wire logic watchdog_enable,
  input wire logic filter_active,
  input wire logic [5:0] filter_len,
  input wire logic [5:0] rc_trim,
  input wire logic [2:0] osc_mode,
  input wire logic clkout_o,
  input wire logic clkout_oe_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [5:0] lo_cnt;
  // saturates so a long brown-out never wraps back below the limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lo_cnt <= 6'h00;
    else lo_cnt <= supply_below_trip ? lo_cnt + 6'(lo_cnt != 6'h3f) : 6'h00;
  end
  property p_green; config_valid |-> start_green == !option_word0[10] && low_power == !option_word0[9]; endproperty
  a_green: assert property (p_green) else $error("start mode or power level wrong");
  property p_level; config_valid |-> lowvolt_level == option_word0[8:7]; endproperty
  a_level: assert property (p_level) else $error("trip level wrong");
  property p_lvr; $rose(lowvolt_reset) |-> lo_cnt >= 6'h30 && lowvolt_level != 2'h3; endproperty
  a_lvr: assert property (p_lvr) else $error("brown-out reset too early");
  property p_wdt; config_valid |-> watchdog_enable == !option_word0[5]; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog enable wrong");
  property p_len; config_valid |-> filter_len == ((option_word1[3:1] == 3'h4 || !option_word0[4]) ? 6'h08 : 6'h20);
  endproperty
  a_len: assert property (p_len) else $error("filter width wrong");
  property p_filt; filter_active |-> option_word0[3] && config_valid; endproperty
  a_filt: assert property (p_filt) else $error("filter on while disabled");
  property p_clk; config_valid && $past(config_valid) |->
    (osc_mode != 3'h2 ? clkout_oe_n : (option_word1[0] ? !clkout_oe_n : !clkout_o)); endproperty
  a_clk: assert property (p_clk) else $error("clock output drive wrong");
  property p_hold; config_valid && $past(config_valid) |-> $stable({osc_mode, rc_trim, lowvolt_level, start_green});
  endproperty
  a_hold: assert property (p_hold) else $error("setting changed while running");
endmodule
bind option_word_config_decode option_word_checks checks_inst (.pclk, .presetn, .option_word0, .option_word1,
  .supply_below_trip, .config_valid, .start_green, .low_power, .lowvolt_level, .lowvolt_reset, .watchdog_enable,
  .filter_active, .filter_len, .rc_trim, .osc_mode, .clkout_o, .clkout_oe_n);

// ### option_word_config_decode_tb.sv
// self-checking bench for the option word decoder
`timescale 1ns/100ps
`include "option_word_consts.vh"
module option_word_config_decode_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, supply_below_trip = 0;
  logic shared_reset_io_pin_in = 1, pready, pslverr, err, config_valid, start_green, low_power, lowvolt_reset;
  logic reset_pin_is_reset, ext_reset_n, gpio_in, watchdog_enable, filter_active, slow_clock_32k;
  logic osc_mode_valid, clkout_o, clkout_oe_n;
  logic [1:0] lowvolt_level, rc_freq;
  logic [2:0] osc_mode;
  logic [5:0] filter_len, rc_trim;
  logic [11:0] paddr = 0;
  logic [14:0] option_word0, option_word1, w0, w1, img0 = `OPT0_DEFAULT, img1 = `OPT1_DEFAULT;
  logic [31:0] pwdata = 0, prdata, rd, seed = 32'ha3d5774b;
  int failures = 0, n_compared = 0;
  option_programmer option_programmer_inst (.img0(img0), .img1(img1), .word0(option_word0), .word1(option_word1));
  option_word_config_decode option_word_config_decode_inst (.*);
  initial forever #50 pclk = ~pclk;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [5:0] exp_len(input logic [14:0] a, input logic [14:0] b);
    return (b[3:1] == `OSC_XTAL_LOW || !a[`W0_FILT_WIDTH]) ? 6'h08 : 6'h20;
  endfunction
  task stop_test;
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // look between edges so the design's edge updates have settled
    for (k = 0; k < 20; k++) begin
      @(negedge pclk);
      if (pready === 1) break;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    chk(pready, 1);
    if (pready !== 1) stop_test;
    // the access completes at this edge; release only after it
    @(posedge pclk);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task brownout(input int n);
    supply_below_trip <= 1;
    repeat (n) @(posedge pclk);
    supply_below_trip <= 0;
  endtask
  initial begin
    for (int i = 0; i < 8; i++) begin
      presetn <= 0;
      seed = nxt(seed);
      w0 = seed[14:0];
      seed = nxt(seed);
      w1 = seed[14:0];
      w0[8:7] = i[1:0];
      w1[6:5] = i[1:0];
      w1[3:1] = 3'(i % 6 + 2);
      // low crystal case must meet a wide width request
      if (w1[3:1] == `OSC_XTAL_LOW) w0[`W0_FILT_WIDTH] = 1'b1;
      img0 <= w0;
      img1 <= w1;
      w1[14] = 1'b1;
      repeat (16) @(posedge pclk);
      presetn <= 1;
      for (int k = 0; k < 10 && config_valid !== 1; k++) @(posedge pclk);
      chk(config_valid, 1);
      if (config_valid !== 1) stop_test;
      chk(start_green, !w0[10]);
      chk(low_power, !w0[9]);
      chk(lowvolt_level, w0[8:7]);
      chk(reset_pin_is_reset, !w0[6]);
      chk({ext_reset_n, gpio_in}, 2'h3);
      chk(watchdog_enable, !w0[5]);
      chk(filter_len, exp_len(w0, w1));
      chk(slow_clock_32k, !w1[13]);
      chk(rc_trim, w1[12:7]);
      chk(rc_freq, w1[6:5]);
      chk({osc_mode_valid, osc_mode}, {1'b1, w1[3:1]});
      apb(1, `REG_WORD0, 32'h0);
      chk(err, 1);
      apb(0, `REG_WORD1, 32'h0);
      chk(rd, w1);
      apb(0, 12'h010, 32'h0);
      chk(err, 1);
      apb(1, `REG_MODE, 32'h1);
      repeat (2) @(posedge pclk);
      chk(filter_active, 0);
      apb(1, `REG_MODE, 32'h0);
      repeat (2) @(posedge pclk);
      chk(filter_active, w0[3]);
      brownout(20);
      repeat (3) @(posedge pclk);
      chk(lowvolt_reset, 0);
      brownout(60);
      chk(lowvolt_reset, w0[8:7] != 2'h3);
      repeat (60) @(posedge pclk);
      chk(lowvolt_reset, 0);
    end
    stop_test;
  end
endmodule
